// file: core/phy_strap_config_latch.v
// Strap configuration latch with MII pin handling, APB registers, irq.
// Assumes straps and MAC pins are asynchronous to core_clk (25 MHz).
// Functional notes
// R1: Sample all straps at reset release and configure from them.
// R2: Strap pins are released inputs during reset, drive outputs after. The interrupt pin only ever pulls low and is released otherwise.
// R3: Address bits 0,1,2 come from receive data lines 3,2,1.
// R4: Address defaults to 00001; bits 4:3 are always zero.
// R5: Mode 000 normal no auto crossover, 010 normal with it.
// R6: Mode 110 selects back-to-back with auto crossover.
// R7: Inverted auto-negotiation strap lands in control bit 12.
// R8: Low test-tree strap at release enables test-tree mode.
// R9: High filter strap at release disables the emission filter.
// R10: Receive nibble follows receive clock, valid only with data valid.
// R11: Transmit nibble taken on transmit clock only while enable high.
// R12: Interrupt pin polarity programmable, active low by default.
// R13: Straight wiring: pair one sends; crossover swaps the pairs.
// R14: Station manager drives management clock and synchronous data.
// R15: Signal detect output high while receive signal is present.
// R16: Internal strap values stay fixed until the next chip reset.
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "phy_strap_defs.vh"

module phy_strap_config_latch (
	// Clock and reset
	input  wire        core_clk,
	input  wire        nrst,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Receive pins, strap inputs during reset
	input  wire [3:0]  rxd_in,
	output reg  [3:0]  rxd_out,
	output reg  [3:0]  rxd_oe_n,
	input  wire        rx_dv_in,
	output reg         rx_dv_out,
	output reg         rx_dv_oe_n,
	input  wire        rx_er_in,
	output reg         rx_er_out,
	output reg         rx_er_oe_n,
	input  wire        crs_in,
	output reg         crs_out,
	output reg         crs_oe_n,
	input  wire        rxc_in,
	output reg         rxc_out,
	output reg         rxc_oe_n,
	// Transmit pins: clock out to the MAC, enable and data from it
	output reg         txc,
	input  wire        tx_en,
	input  wire [3:0]  txd,
	// Interrupt pin, test-tree strap during reset
	input  wire        irq_in,
	output reg         irq_out,
	output reg         irq_oe_n,
	// Line side
	input  wire        line_energy,
	input  wire        line_rx_valid,
	input  wire [3:0]  line_rx_data,
	input  wire        line_mdix_req,
	output reg  [3:0]  line_tx_data,
	output reg         line_tx_valid,
	output reg         line_signal_detect,
	output reg         pair_swap,
	// Latched configuration
	output reg  [4:0]  mgmt_station_address,
	output reg         back_to_back,
	output reg         auto_mdix_en,
	output reg         an_enable,
	output reg         test_tree_en,
	output reg         emission_filter_disable_strap,
	// Interrupt line to the system
	output reg         sys_irq
);

	// Synchroniser stages for straps and transmit pins
	wire [`SYNC_W-1:0] raw;
	reg  [`SYNC_W-1:0] s1_q;
	reg  [`SYNC_W-1:0] s2_q;
	reg  [`SYNC_W-1:0] s3_q;
	reg  [1:0]         settle_q;
	reg                latched_q;
	reg  [2:0]         mode_q;
	reg  [2:0]         div_q;
	reg                ctl_force_q;
	reg                ctl_high_q;
	reg  [`EV_W-1:0]   ist_q;
	reg  [`EV_W-1:0]   imask_q;
	reg                sig_prev_q;
	reg                rxv_prev_q;
	reg                txv_prev_q;
	wire               edge_now;
	wire               fall_now;
	wire               acc;
	wire               wr;
	wire               rd;
	wire [`EV_W-1:0]   ev;
	wire               irq_act;
	wire [3:0]         tx_s;
	wire               txen_s;

	assign raw = {tx_en, txd, irq_in, rx_er_in, rx_dv_in, crs_in,
		rxc_in, rxd_in[0], rxd_in[1], rxd_in[2], rxd_in[3]};
	assign tx_s   = s3_q[`SP_TXD+3:`SP_TXD];
	assign txen_s = s3_q[`SP_TXEN];

	// Three-flop synchronisers on every strap and MAC pin input (line side is not synchronised), one driver each
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			s1_q <= {`SYNC_W{1'b0}};
			s2_q <= {`SYNC_W{1'b0}};
			s3_q <= {`SYNC_W{1'b0}};
		end else begin
			s1_q <= raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Strap capture once synchronisers have settled after release
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			settle_q             <= 2'h0;
			latched_q            <= 1'b0;
			mgmt_station_address <= `ADDR_DEFAULT;
			mode_q               <= `MODE_NORMAL;
			back_to_back         <= 1'b0;
			auto_mdix_en         <= 1'b0;
			test_tree_en         <= 1'b0;
			emission_filter_disable_strap <= 1'b0;
		end else if (!latched_q) begin
			if (settle_q != `SETTLE_CYC) begin
				settle_q <= settle_q + 2'h1;
			end else if (s2_q[`SP_W-1:0] == s3_q[`SP_W-1:0]) begin // R1
				latched_q <= 1'b1;
				mgmt_station_address <= {`ADDR_UPPER,
					s3_q[`SP_AD2], s3_q[`SP_AD1], s3_q[`SP_AD0]}; // R3 R4
				mode_q <= s3_q[`SP_M2:`SP_M0];
				case (s3_q[`SP_M2:`SP_M0])
					`MODE_AUTO_X: begin
						back_to_back <= 1'b0; // R5
						auto_mdix_en <= 1'b1;
					end
					`MODE_B2B: begin
						back_to_back <= 1'b1; // R6
						auto_mdix_en <= 1'b1;
					end
					default: begin
						back_to_back <= 1'b0; // R5
						auto_mdix_en <= 1'b0;
					end
				endcase
				test_tree_en <= ~s3_q[`SP_TREE]; // R8
				emission_filter_disable_strap <= s3_q[`SP_FILT]; // R9
			end
		end
		// Nothing reloads until the next reset
	end // R16

	// MII clock divider shared by receive and transmit clocks
	assign edge_now = (div_q == `HALF_CYC);
	assign fall_now = edge_now & txc;

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			div_q <= 3'h0;
			txc   <= 1'b0;
		end else if (edge_now) begin
			div_q <= 3'h0;
			txc   <= ~txc;
		end else begin
			div_q <= div_q + 3'h1;
		end
	end

	// Receive pins: released until latched, then driven
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rxd_oe_n   <= 4'hF; // R2
			rx_dv_oe_n <= 1'b1;
			rx_er_oe_n <= 1'b1;
			crs_oe_n   <= 1'b1;
			rxc_oe_n   <= 1'b1;
			rxd_out    <= 4'h0;
			rx_dv_out  <= 1'b0;
			rx_er_out  <= 1'b0;
			crs_out    <= 1'b0;
			rxc_out    <= 1'b0;
		end else begin
			rxd_oe_n   <= {4{~latched_q}}; // R2
			rx_dv_oe_n <= ~latched_q;
			rx_er_oe_n <= ~latched_q;
			crs_oe_n   <= ~latched_q;
			rxc_oe_n   <= ~latched_q;
			if (edge_now) begin
				rxc_out <= ~txc;
			end
			// Update on falling clock so data is stable at the rise
			if (fall_now) begin
				rx_dv_out <= line_rx_valid;
				rxd_out   <= line_rx_valid ? line_rx_data : 4'h0; // R10
				crs_out   <= line_rx_valid | txen_s;
			end
		end
	end

	// Transmit nibble captured on falling edge while enable is high
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			line_tx_data  <= 4'h0;
			line_tx_valid <= 1'b0;
		end else begin
			line_tx_valid <= fall_now & txen_s & latched_q; // R11
			if (fall_now & txen_s) begin
				line_tx_data <= tx_s; // R11
			end
		end
	end

	// Signal detect and pair orientation
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			line_signal_detect <= 1'b0;
			pair_swap          <= 1'b0;
		end else begin
			line_signal_detect <= line_energy; // R15
			pair_swap <= auto_mdix_en ? line_mdix_req : ctl_force_q; // R13
		end
	end

	// APB decode: no wait state, answer in first access cycle
	assign acc = psel & penable & pready;
	assign wr  = acc & pwrite;
	assign rd  = acc & ~pwrite;

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= psel & ~penable & ~pready;
			pslverr <= 1'b0;
			if (psel & ~penable) begin
				prdata <= 32'h0;
				case (paddr)
					`OFS_BASIC_CTRL: begin
						prdata[`CTL_MDIX_FORCE] <= ctl_force_q;
						prdata[`CTL_IRQ_HIGH]   <= ctl_high_q;
						prdata[`CTL_AN_ENABLE]  <= an_enable;
					end
					`OFS_STRAP_STAT: begin
						prdata[`STS_ADDR_LSB+4:`STS_ADDR_LSB]
							<= mgmt_station_address;
						prdata[`STS_MODE_LSB+2:`STS_MODE_LSB] <= mode_q;
						prdata[`STS_FILTER_DIS] <=
							emission_filter_disable_strap;
						prdata[`STS_TEST_TREE] <= test_tree_en;
						prdata[`STS_LATCHED]   <= latched_q;
					end
					`OFS_INT_STAT: prdata[`EV_W-1:0] <= ist_q;
					`OFS_INT_MASK: prdata[`EV_W-1:0] <= imask_q;
					default: pslverr <= ~pwrite | (paddr != `OFS_BASIC_CTRL);
				endcase
			end else if (!psel) begin
				prdata <= 32'h0;
			end
		end
	end

	// Writable control bits; auto-negotiation preset from its strap
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ctl_force_q <= 1'b0;
			ctl_high_q  <= 1'b0; // R12
			an_enable   <= 1'b0;
			imask_q     <= {`EV_W{1'b0}};
		end else begin
			if (!latched_q && settle_q == `SETTLE_CYC &&
				s2_q[`SP_W-1:0] == s3_q[`SP_W-1:0]) begin
				an_enable <= ~s3_q[`SP_AN]; // R7
			end else if (wr && paddr == `OFS_BASIC_CTRL) begin
				an_enable <= pwdata[`CTL_AN_ENABLE];
			end
			if (wr && paddr == `OFS_BASIC_CTRL) begin
				ctl_force_q <= pwdata[`CTL_MDIX_FORCE];
				ctl_high_q  <= pwdata[`CTL_IRQ_HIGH]; // R12
			end
			if (wr && paddr == `OFS_INT_MASK) begin
				imask_q <= pwdata[`EV_W-1:0];
			end
		end
	end

	// Events; a read clears only the bits it returned, set wins
	assign ev = {txen_s & ~txv_prev_q, line_rx_valid & ~rxv_prev_q,
		line_energy & ~sig_prev_q};

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sig_prev_q <= 1'b0;
			rxv_prev_q <= 1'b0;
			txv_prev_q <= 1'b0;
			ist_q      <= {`EV_W{1'b0}};
		end else begin
			sig_prev_q <= line_energy;
			rxv_prev_q <= line_rx_valid;
			txv_prev_q <= txen_s;
			if (rd && paddr == `OFS_INT_STAT) begin
				ist_q <= (ist_q & ~prdata[`EV_W-1:0]) | ev;
			end else begin
				ist_q <= ist_q | ev;
			end
		end
	end

	// Interrupt pin only pulls low; released level reads high
	assign irq_act = |(ist_q & imask_q);

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sys_irq  <= 1'b0;
			irq_out  <= 1'b0;
			irq_oe_n <= 1'b1; // R2
		end else begin
			sys_irq  <= irq_act;
			irq_out  <= ~(irq_act ^ ctl_high_q); // R12
			irq_oe_n <= ~latched_q | ~(irq_act ^ ctl_high_q); // R12
		end
	end

endmodule // phy_strap_config_latch

`default_nettype wire

// file: shared/phy_strap_defs.vh
// Constants for the strap configuration latch and its MII pin logic.
// Assumes a 25 MHz core clock and a 32-bit APB register bus.
`ifndef PHY_STRAP_DEFS_VH
`define PHY_STRAP_DEFS_VH

// Register byte offsets
`define OFS_BASIC_CTRL   8'h00
`define OFS_STRAP_STAT   8'h04
`define OFS_INT_STAT     8'h08
`define OFS_INT_MASK     8'h0C

// Basic control fields
`define CTL_MDIX_FORCE   0
`define CTL_IRQ_HIGH     1
`define CTL_AN_ENABLE    12

// Strap status fields
`define STS_ADDR_LSB     0
`define STS_MODE_LSB     8
`define STS_FILTER_DIS   12
`define STS_TEST_TREE    13
`define STS_LATCHED      14

// Interrupt event bits
`define EV_SIGNAL        0
`define EV_RX_START      1
`define EV_TX_START      2
`define EV_W             3

// Strap vector positions
`define SP_AD0           0
`define SP_AD1           1
`define SP_AD2           2
`define SP_AN            3
`define SP_M0            4
`define SP_M1            5
`define SP_M2            6
`define SP_FILT          7
`define SP_TREE          8
`define SP_W             9
`define SP_TXD           9
`define SP_TXEN          13
`define SYNC_W           14

// Mode strap codes
`define MODE_NORMAL      3'h0
`define MODE_AUTO_X      3'h2
`define MODE_B2B         3'h6

// Reset values
`define ADDR_DEFAULT     5'h01
`define ADDR_UPPER       2'h0

// Timing: sync settle cycles and half MII clock period
`define SETTLE_CYC       2'h3
`define HALF_CYC         3'h3
`endif

// file: tb/mac_model.sv
// MAC transmit model: sends four nibbles per burst on txc.
// Assumes txc comes from the device; pins change just after txc rises.
`timescale 1ns/1ns
`default_nettype none
module mac_model (
	// Clock and control
	input  wire        txc,
	input  wire        nrst,
	input  wire        go,
	// Transmit pins
	output logic       tx_en,
	output logic [3:0] txd
);
	logic [2:0] idx_q;
	// Burst of nibbles, idle data inverted each clock between bursts
	always @(posedge txc or negedge nrst) begin
		if (!nrst) begin
			tx_en <= 1'b0;
			txd <= 4'h0;
			idx_q <= 3'h0;
		end else if (go && idx_q != 3'h4) begin
			tx_en <= 1'b1;
			txd <= {idx_q[1:0], 2'h3};
			idx_q <= idx_q + 3'h1;
		end else begin
			tx_en <= 1'b0;
			txd <= ~txd;
			if (!go)
				idx_q <= 3'h0;
		end
	end
endmodule // mac_model
`default_nettype wire

// file: tb/phy_strap_monitor.sv
// Checker for strap latch pin timing, bus answers and configuration.
// Assumes binding onto phy_strap_config_latch; one core_clk domain.
`timescale 1ns/1ns
`default_nettype none
module phy_strap_monitor (
	// Clock, reset and bus
	input wire        core_clk,
	input wire        nrst,
	input wire        psel,
	input wire        penable,
	input wire [7:0]  paddr,
	input wire        pready,
	input wire        pslverr,
	// Pins
	input wire        tx_en,
	input wire        txc,
	input wire        line_tx_valid,
	input wire [3:0]  rxd_out,
	input wire        rx_dv_out,
	input wire [3:0]  rxd_oe_n,
	input wire        line_energy,
	input wire        line_signal_detect,
	// Configuration
	input wire [4:0]  mgmt_station_address,
	input wire        back_to_back,
	input wire        auto_mdix_en
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// Bus steps and clock shape
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence answer_s;
		pready ##1 !pready;
	endsequence
	sequence txc_high_s;
		(txc)[*4];
	endsequence
	chk_apb_answer: assert property (setup_s |=> answer_s)
		else $error("bus answer not one cycle after setup");
	chk_apb_unmapped: assert property (pready |-> pslverr ==
		!(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}))
		else $error("error flag wrong for address");
	chk_pins_release: assert property (!$past(nrst) |->
		(rxd_oe_n == 4'hF)[*3] ##[1:30] (rxd_oe_n == 4'h0))
		else $error("pin drive enable timing wrong");
	chk_config_hold: assert property (rxd_oe_n == 4'h0 &&
		$past(rxd_oe_n) == 4'h0 |-> $stable(mgmt_station_address)
		&& $stable({back_to_back, auto_mdix_en}))
		else $error("latched configuration changed");
	chk_b2b_mdix: assert property (back_to_back |-> auto_mdix_en)
		else $error("back to back without crossover");
	chk_rx_idle_zero: assert property (!rx_dv_out |-> rxd_out == 4'h0)
		else $error("receive nibble without valid");
	chk_txc_shape: assert property ($rose(txc) |-> txc_high_s ##1
		(!txc)[*4])
		else $error("transmit clock shape wrong");
	chk_tx_no_enable: assert property ((!tx_en)[*8] |->
		!line_tx_valid)
		else $error("nibble accepted without enable");
	chk_line_signal_detect_follow: assert property ($past(nrst) |->
		line_signal_detect == $past(line_energy))
		else $error("signal detect does not follow energy");
endmodule // phy_strap_monitor
bind phy_strap_config_latch phy_strap_monitor phy_strap_monitor_inst (
	.core_clk, .nrst, .psel, .penable, .paddr, .pready, .pslverr,
	.tx_en, .txc, .line_tx_valid, .rxd_out, .rx_dv_out, .rxd_oe_n,
	.line_energy, .line_signal_detect, .mgmt_station_address,
	.back_to_back, .auto_mdix_en);
`default_nettype wire

// file: tb/tb_phy_strap_config_latch.sv
// Bench for the strap latch: straps, bus, interrupt and MAC transmit.
// Assumes the design, the MAC model and the checker compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "phy_strap_defs.vh"
module tb_phy_strap_config_latch;
	logic        core_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
	logic        line_energy = 0, go = 0;
	logic        line_rx_valid = 0, line_mdix_req = 1;
	logic [3:0]  line_rx_data = 4'h0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [8:0]  st = 9'h109;
	int          bad_count = 0, compares = 0, cyc = 0;
	wire [31:0]  prdata;
	wire [4:0]   mgmt_station_address;
	wire [3:0]   rxd_in, rxd_out, rxd_oe_n, txd, line_tx_data;
	wire pready, pslverr, rx_dv_in, rx_dv_out, rx_dv_oe_n, rx_er_in;
	wire rx_er_out, rx_er_oe_n, crs_in, crs_out, crs_oe_n, rxc_in, rxc_out;
	wire rxc_oe_n, txc, tx_en, irq_in, irq_out, irq_oe_n, line_tx_valid;
	wire line_signal_detect, pair_swap, back_to_back, auto_mdix_en;
	wire an_enable, test_tree_en, emission_filter_disable_strap, sys_irq;
	// Clock
	always #20 core_clk = ~core_clk;
	// Pin level: strap resistor while released, device drive otherwise
	assign rxd_in = {rxd_oe_n[3] ? st[0] : rxd_out[3],
		rxd_oe_n[2] ? st[1] : rxd_out[2],
		rxd_oe_n[1] ? st[2] : rxd_out[1],
		rxd_oe_n[0] ? st[3] : rxd_out[0]};
	assign rxc_in = rxc_oe_n ? st[4] : rxc_out;
	assign crs_in = crs_oe_n ? st[5] : crs_out;
	assign rx_dv_in = rx_dv_oe_n ? st[6] : rx_dv_out;
	assign rx_er_in = rx_er_oe_n ? st[7] : rx_er_out;
	assign irq_in = irq_oe_n ? st[8] : irq_out;
	// Design and MAC
	phy_strap_config_latch phy_strap_config_latch_inst (.core_clk, .nrst,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .rxd_in, .rxd_out, .rxd_oe_n, .rx_dv_in, .rx_dv_out,
		.rx_dv_oe_n, .rx_er_in, .rx_er_out, .rx_er_oe_n, .crs_in,
		.crs_out, .crs_oe_n, .rxc_in, .rxc_out, .rxc_oe_n, .txc, .tx_en,
		.txd, .irq_in, .irq_out, .irq_oe_n, .line_energy,
		.line_rx_valid, .line_rx_data, .line_mdix_req,
		.line_tx_data, .line_tx_valid, .line_signal_detect, .pair_swap,
		.mgmt_station_address, .back_to_back, .auto_mdix_en, .an_enable,
		.test_tree_en, .emission_filter_disable_strap, .sys_irq);
	mac_model mac_model_inst (.txc, .nrst, .go, .tx_en, .txd);
	task automatic chk(input [31:0] seen, input [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input w, input [7:0] a, input [31:0] d,
		output [31:0] r, output e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic t_strap(input [8:0] s);
		logic [31:0] r;
		logic        e;
		st <= s;
		nrst <= 1'b0;
		repeat (20) @(posedge core_clk);
		chk(mgmt_station_address, 5'h01);
		chk(rxd_oe_n, 4'hF);
		nrst <= 1'b1;
		repeat (12) @(posedge core_clk);
		st <= ~s;
		repeat (4) @(posedge core_clk);
		chk(rxd_oe_n, 4'h0);
		chk(mgmt_station_address, {2'h0, s[2:0]});
		chk({back_to_back, auto_mdix_en, pair_swap},
			{s[6:4] == 3'h6, {2{s[6:4] == 3'h6 || s[6:4] == 3'h2}}});
		chk(an_enable, !s[3]);
		chk(test_tree_en, !s[8]);
		chk(emission_filter_disable_strap, s[7]);
		apb(1'b0, `OFS_BASIC_CTRL, 32'h0, r, e);
		chk(r[12], !s[3]);
		apb(1'b0, `OFS_STRAP_STAT, 32'h0, r, e);
		chk({r[14], r[4:0]}, {1'b1, 2'h0, s[2:0]});
		chk(r[13:8], {!s[8], s[7], 1'b0, s[6:4]});
		$display("strap test %h done", s);
	endtask
	task automatic t_irq;
		logic [31:0] r;
		logic        e;
		apb(1'b1, `OFS_INT_MASK, 32'h0, r, e);
		line_energy <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk({line_signal_detect, sys_irq, irq_oe_n}, 3'b101);
		apb(1'b1, `OFS_INT_MASK, 32'h1, r, e);
		repeat (3) @(posedge core_clk);
		chk({sys_irq, irq_oe_n, irq_out}, 3'b100);
		apb(1'b0, `OFS_INT_STAT, 32'h0, r, e);
		chk(r[0], 1'b1);
		repeat (3) @(posedge core_clk);
		chk({sys_irq, irq_oe_n}, 2'b01);
		apb(1'b1, `OFS_BASIC_CTRL, 32'h2, r, e);
		line_energy <= 1'b0;
		@(posedge core_clk);
		chk({irq_oe_n, irq_out}, 2'b00);
		line_energy <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk({sys_irq, irq_oe_n, irq_out}, 3'b111);
		apb(1'b0, 8'h10, 32'h0, r, e);
		chk(e, 1'b1);
		chk(r, 32'h0);
		$display("interrupt test done");
	endtask
	task automatic t_rx;
		logic [31:0] r;
		logic        e;
		apb(1'b1, `OFS_BASIC_CTRL, 32'h1, r, e);
		line_rx_valid <= 1'b1;
		line_rx_data <= 4'hA;
		repeat (10) @(posedge core_clk);
		chk({rx_dv_out, rxd_out, crs_out, pair_swap}, 7'b1101011);
		chk(rxc_out, txc);
		line_rx_valid <= 1'b0;
		line_rx_data <= 4'h5;
		repeat (10) @(posedge core_clk);
		chk({rx_dv_out, rxd_out, crs_out}, 6'h00);
		$display("receive test done");
	endtask
	task automatic t_tx;
		logic [3:0] got [$];
		int         n;
		go <= 1'b1;
		for (n = 0; n < 200 && got.size() < 4; n++) begin
			@(posedge core_clk);
			if (line_tx_valid === 1'b1)
				got.push_back(line_tx_data);
		end
		go <= 1'b0;
		chk(got.size(), 4);
		foreach (got[i])
			chk(got[i], {i[1:0], 2'h3});
		$display("transmit test done");
	endtask
	task automatic final_report;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Cycle ceiling against hangs
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			final_report;
		end
	end
	// Main sequence
	initial begin
		t_strap(9'h109);
		t_strap(9'h0A6);
		t_strap(9'h167);
		t_strap(9'h1D8);
		t_strap(9'h1B8);
		t_irq;
		t_rx;
		t_tx;
		final_report;
	end
endmodule // tb_phy_strap_config_latch
`default_nettype wire
